// ==== src/crl_limit_check.sv ====
// one channel's limit comparator
// assumes result and limits are stable while sample is high
`timescale 1ns/100ps
module crl_limit_check (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sample,
  input wire logic [11:0] result,
  input wire logic [7:0] highLimit,
  input wire logic [7:0] lowLimit,
  output logic highFlag,
  output logic lowFlag
);
  import crl_pkg::*;

  logic [7:0] upperByte;
  logic highFlag_next;
  logic lowFlag_next;

  // ==========================================================
  // compare
  // only whole degrees are compared against the limits
  assign upperByte = result[LIMIT_MSB:LIMIT_LSB];
  assign highFlag_next = sample ? (upperByte > highLimit) : highFlag;
  assign lowFlag_next = sample ? (upperByte < lowLimit) : lowFlag;

  // flags follow the latest completed conversion
  always_ff @(posedge clock) begin
    if (!rstn) begin
      highFlag <= 1'b0;
      lowFlag <= 1'b0;
    end else begin
      highFlag <= highFlag_next;
      lowFlag <= lowFlag_next;
    end
  end
endmodule

// ==== src/crl_pkg.sv ====
// constants for the conversion-rate and limit register bank
// assumes a 40 MHz core clock and a pointer-addressed register port
package crl_pkg;

  // ==========================================================
  // pointer addresses
  localparam logic [7:0] RD_RATE = 8'h04;
  localparam logic [7:0] WR_RATE = 8'h0A;
  localparam logic [7:0] RD_LOC_HIGH = 8'h05;
  localparam logic [7:0] WR_LOC_HIGH = 8'h0B;
  localparam logic [7:0] RD_LOC_LOW = 8'h06;
  localparam logic [7:0] WR_LOC_LOW = 8'h0C;
  localparam logic [7:0] RD_REM_HIGH = 8'h07;
  localparam logic [7:0] WR_REM_HIGH = 8'h0D;
  localparam logic [7:0] RD_REM_LOW = 8'h08;
  localparam logic [7:0] WR_REM_LOW = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT = 8'h0F;

  // ==========================================================
  // field layout and reset values
  localparam int RATE_MSB = 3;
  localparam int LIMIT_MSB = 11; // limits hold result bits 11:4
  localparam int LIMIT_LSB = 4;
  localparam logic [3:0] RATE_RST = 4'h8;
  localparam logic [3:0] RATE_FASTEST = 4'h9;
  localparam logic [7:0] HIGH_RST = 8'h55;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ==========================================================
  // timing
  localparam longint CLK_PERIOD_NS = 25;
  localparam longint FASTEST_PERIOD_NS = 31_250_000; // 0.03125 s at code 09h
  localparam longint CONV_TIME_NS = 10_000_000; // fixed conversion length
  localparam longint FASTEST_PERIOD_CYC = FASTEST_PERIOD_NS / CLK_PERIOD_NS;
  localparam longint CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SCH_CONVERT,
    SCH_IDLE,
    SCH_HALT
  } crl_sched_t;

endpackage

// ==== src/crl_rate_limit_regs.sv ====
// conversion scheduler with rate and threshold registers
// assumes a serial front end giving decoded pointer writes and reads,
// and a converter reporting results with a one-cycle pulse
`timescale 1ns/100ps
module crl_rate_limit_regs #(
  parameter longint FAST_PERIOD_CYCLES = crl_pkg::FASTEST_PERIOD_CYC,
  parameter longint CONV_CYCLES = crl_pkg::CONV_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wrStrobe,
  input wire logic [7:0] wrPtr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdPtr,
  output logic [7:0] rdData,
  input wire logic power_down_bit,
  output logic convStart,
  output logic convBusy,
  output logic shutdownIdle,
  input wire logic resultValid,
  input wire logic [11:0] localResult,
  input wire logic [11:0] remoteResult,
  output logic localHighFlag,
  output logic localLowFlag,
  output logic remoteHighFlag,
  output logic remoteLowFlag
);
  import crl_pkg::*;

  // ==========================================================
  // register storage
  logic [3:0] rate_code_reg;
  logic [7:0] local_upper_threshold_bits_reg;
  logic [7:0] local_lower_threshold_bits_reg;
  logic [7:0] remote_upper_threshold_bits_reg;
  logic [7:0] remote_lower_threshold_bits_reg;
  logic [7:0] rdData_next;

  // write decode
  logic wrRate;
  logic wrLocHigh;
  logic wrLocLow;
  logic wrRemHigh;
  logic wrRemLow;
  logic wrTrigger;

  assign wrRate = wrStrobe && (wrPtr == WR_RATE);
  assign wrLocHigh = wrStrobe && (wrPtr == WR_LOC_HIGH);
  assign wrLocLow = wrStrobe && (wrPtr == WR_LOC_LOW);
  assign wrRemHigh = wrStrobe && (wrPtr == WR_REM_HIGH);
  assign wrRemLow = wrStrobe && (wrPtr == WR_REM_LOW);
  assign wrTrigger = wrStrobe && (wrPtr == WR_ONE_SHOT);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rate_code_reg <= RATE_RST;
    end else if (wrRate) begin
      rate_code_reg <= wrData[RATE_MSB:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      local_upper_threshold_bits_reg <= HIGH_RST;
    end else if (wrLocHigh) begin
      local_upper_threshold_bits_reg <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      local_lower_threshold_bits_reg <= LOW_RST;
    end else if (wrLocLow) begin
      local_lower_threshold_bits_reg <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      remote_upper_threshold_bits_reg <= HIGH_RST;
    end else if (wrRemHigh) begin
      remote_upper_threshold_bits_reg <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      remote_lower_threshold_bits_reg <= LOW_RST;
    end else if (wrRemLow) begin
      remote_lower_threshold_bits_reg <= wrData;
    end
  end

  // ==========================================================
  // read path
  // reserved bits zero
  always_comb begin
    case (rdPtr)
      RD_RATE: rdData_next = {4'h0, rate_code_reg};
      RD_LOC_HIGH: rdData_next = local_upper_threshold_bits_reg;
      RD_LOC_LOW: rdData_next = local_lower_threshold_bits_reg;
      RD_REM_HIGH: rdData_next = remote_upper_threshold_bits_reg;
      RD_REM_LOW: rdData_next = remote_lower_threshold_bits_reg;
      default: rdData_next = UNMAPPED_RD;
    endcase
  end

  // read data is registered, one cycle behind the pointer
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdData_next;
    end
  end

  // ==========================================================
  // conversion scheduler
  crl_sched_t state_reg;
  crl_sched_t state_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [31:0] periodCycles;
  logic [3:0] effCode;
  logic [3:0] shiftAmt;
  logic convDone;
  logic periodDone;
  logic startConv;

  // codes above the fastest one run at the fastest rate
  assign effCode = (rate_code_reg > RATE_FASTEST) ? RATE_FASTEST : rate_code_reg;
  assign shiftAmt = RATE_FASTEST - effCode;
  assign periodCycles = 32'(FAST_PERIOD_CYCLES) << shiftAmt;

  assign convDone = (state_reg == SCH_CONVERT) && (count_reg == 32'(CONV_CYCLES - 1));
  // count runs from the conversion start, so the idle gap absorbs the rate
  assign periodDone = (state_reg == SCH_IDLE) && (count_reg >= periodCycles - 32'd1);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 32'd1;
    startConv = 1'b0;
    case (state_reg)
      SCH_CONVERT: begin
        if (convDone) begin
          state_next = power_down_bit ? SCH_HALT : SCH_IDLE;
        end
      end
      SCH_IDLE: begin
        if (power_down_bit) begin
          state_next = SCH_HALT;
        end else if (periodDone) begin
          state_next = SCH_CONVERT;
          count_next = 32'd0;
          startConv = 1'b1;
        end
      end
      SCH_HALT: begin
        count_next = 32'd0;
        if (!power_down_bit) begin
          state_next = SCH_CONVERT;
          startConv = 1'b1;
        end else if (wrTrigger) begin
          state_next = SCH_CONVERT;
          startConv = 1'b1;
        end
      end
      default: begin
        state_next = SCH_HALT;
        count_next = 32'd0;
      end
    endcase
  end

  // trigger ignored outside halt
  // the scheduler tests wrTrigger only in the halt state and ignores it elsewhere
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_reg <= SCH_CONVERT;
      count_reg <= 32'd0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // start pulse registered so it lines up with the convert state
  always_ff @(posedge clock) begin
    if (!rstn) begin
      convStart <= 1'b1; // first conversion follows reset
    end else begin
      convStart <= startConv;
    end
  end

  assign convBusy = (state_reg == SCH_CONVERT);
  assign shutdownIdle = (state_reg == SCH_HALT);

  // ==========================================================
  // limit comparators, channel 0 local, channel 1 remote
  logic [11:0] chResult [2];
  logic [7:0] chHigh [2];
  logic [7:0] chLow [2];
  logic [1:0] chHighFlag;
  logic [1:0] chLowFlag;

  assign chResult[0] = localResult;
  assign chResult[1] = remoteResult;
  assign chHigh[0] = local_upper_threshold_bits_reg;
  assign chHigh[1] = remote_upper_threshold_bits_reg;
  assign chLow[0] = local_lower_threshold_bits_reg;
  assign chLow[1] = remote_lower_threshold_bits_reg;

  for (genvar ch = 0; ch < 2; ch++) begin : gen_chan
    crl_limit_check u_check (
      .clock(clock),
      .rstn(rstn),
      .sample(resultValid),
      .result(chResult[ch]),
      .highLimit(chHigh[ch]),
      .lowLimit(chLow[ch]),
      .highFlag(chHighFlag[ch]),
      .lowFlag(chLowFlag[ch])
    );
  end

  assign localHighFlag = chHighFlag[0];
  assign localLowFlag = chLowFlag[0];
  assign remoteHighFlag = chHighFlag[1];
  assign remoteLowFlag = chLowFlag[1];
endmodule

// ==== test/crl_conv_model.sv ====
// converter stand-in: one result pulse for each start pulse
// assumes the bench supplies the result values on locIn and remIn
`timescale 1ns/100ps
module crl_conv_model #(
  parameter int LAT = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic convStart,
  input wire logic [11:0] locIn,
  input wire logic [11:0] remIn,
  output logic resultValid,
  output logic [11:0] localResult,
  output logic [11:0] remoteResult
);
  logic [3:0] cntReg;
  // ==========================================================
  // latency count; results inverted outside the pulse so stale data never matches
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cntReg <= 4'h0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= (cntReg == 4'h1);
      cntReg <= convStart ? 4'(LAT) : (cntReg != 4'h0) ? cntReg - 4'h1 : 4'h0;
    end
  end
  assign localResult = resultValid ? locIn : ~locIn;
  assign remoteResult = resultValid ? remIn : ~remIn;
endmodule

// ==== test/crl_rate_limit_regs_sva.sv ====
// checker for the rate and limit register bank
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/100ps
module crl_rate_limit_regs_chk #(
  parameter longint FAST_PERIOD_CYCLES = 40,
  parameter longint CONV_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wrStrobe,
  input wire logic [7:0] wrPtr,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdPtr,
  input logic [7:0] rdData,
  input wire logic power_down_bit,
  input logic convStart,
  input logic convBusy,
  input logic shutdownIdle,
  input wire logic resultValid,
  input wire logic [11:0] localResult,
  input logic localHighFlag,
  input logic localLowFlag
);
  // conversion tail after the first eight busy cycles
  localparam int TAIL = int'(CONV_CYCLES) - 7;
  wire wrTrig = wrStrobe && wrPtr == 8'h0F;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // register port
  rate_upper_zero_a: assert property (rdPtr == 8'h04 |=> rdData[7:4] == 4'h0)
    else $error("rate upper bits not zero");
  rate_store_a: assert property (wrStrobe && wrPtr == 8'h0A ##1 !wrStrobe ##1 rdPtr == 8'h04
    |=> rdData == ($past(wrData, 3) & 8'h0F)) else $error("rate readback wrong");
  lhigh_store_a: assert property (wrStrobe && wrPtr == 8'h0B ##1 !wrStrobe ##1 rdPtr == 8'h05
    |=> rdData == $past(wrData, 3)) else $error("local high readback wrong");
  rhigh_store_a: assert property (wrStrobe && wrPtr == 8'h0D ##1 !wrStrobe ##1 rdPtr == 8'h07
    |=> rdData == $past(wrData, 3)) else $error("remote high readback wrong");
  trig_unread_a: assert property (rdPtr == 8'h0F |=> rdData == 8'h00)
    else $error("trigger pointer readable");
  // ==========================================================
  // scheduler
  trig_start_a: assert property (shutdownIdle && wrTrig |=> convBusy && !shutdownIdle)
    else $error("one-shot did not start");
  start_busy_a: assert property (convStart |-> convBusy)
    else $error("start pulse outside conversion");
  conv_len_a: assert property ($rose(convBusy) |-> convBusy[*8] ##TAIL !convBusy)
    else $error("conversion length wrong");
  halt_hold_a: assert property (shutdownIdle && power_down_bit && !wrTrig |=> shutdownIdle)
    else $error("left shutdown unasked");
  resume_now_a: assert property (shutdownIdle && !power_down_bit |=> convBusy)
    else $error("no resume after shutdown cleared");
  // ==========================================================
  // limit flags
  cold_high_a: assert property (resultValid && localResult[11:4] == 8'h00
    |=> !localHighFlag) else $error("high flag on zero result");
  flag_hold_a: assert property (!resultValid |=> $stable(localHighFlag)
    && $stable(localLowFlag)) else $error("flags moved without result");
endmodule
bind crl_rate_limit_regs crl_rate_limit_regs_chk #(.FAST_PERIOD_CYCLES(FAST_PERIOD_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) i_crl_rate_limit_regs_chk (.clock(clock), .rstn(rstn),
  .wrStrobe(wrStrobe), .wrPtr(wrPtr), .wrData(wrData), .rdPtr(rdPtr), .rdData(rdData),
  .power_down_bit(power_down_bit), .convStart(convStart), .convBusy(convBusy),
  .shutdownIdle(shutdownIdle), .resultValid(resultValid), .localResult(localResult),
  .localHighFlag(localHighFlag), .localLowFlag(localLowFlag));

// ==== test/crl_rate_limit_regs_tb_top.sv ====
// testbench: register port, scheduler periods, shutdown one-shots, flags
// assumes short scheduler counts; expectations queued by the driver
`timescale 1ns/100ps
module crl_rate_limit_regs_tb_top;
  import crl_pkg::*;
  localparam int FAST = 40;
  logic clock, rstn, wrStrobe, look, lookD, flagD, powerDown, convStart, convBusy;
  logic shutdownIdle, resultValid, lhF, llF, rhF, rlF;
  logic [7:0] wrPtr, wrData, rdPtr, rdData, d, lv, rv, expQ[$], flagQ[$];
  logic [11:0] locIn, remIn, localResult, remoteResult;
  logic [7:0] rsP[8] = '{RD_RATE, RD_LOC_HIGH, RD_LOC_LOW, RD_REM_HIGH, RD_REM_LOW,
    WR_ONE_SHOT, WR_RATE, 8'h03};
  logic [7:0] rsV[8] = '{8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wrP[5] = '{WR_RATE, WR_LOC_HIGH, WR_LOC_LOW, WR_REM_HIGH, WR_REM_LOW};
  logic [7:0] codes[4] = '{8'h09, 8'h08, 8'h07, 8'h0C};
  logic [7:0] lt[4] = '{8'h41, 8'h40, 8'h00, 8'h10};
  logic [7:0] rt[4] = '{8'h51, 8'h50, 8'h1F, 8'h20};
  int nErrors = 0;
  int totalChecks = 0;
  int cyc;
  crl_rate_limit_regs #(.FAST_PERIOD_CYCLES(FAST), .CONV_CYCLES(10)) i_crl_rate_limit_regs (
    .clock(clock), .rstn(rstn), .wrStrobe(wrStrobe), .wrPtr(wrPtr), .wrData(wrData),
    .rdPtr(rdPtr), .rdData(rdData), .power_down_bit(powerDown), .convStart(convStart),
    .convBusy(convBusy), .shutdownIdle(shutdownIdle), .resultValid(resultValid),
    .localResult(localResult), .remoteResult(remoteResult), .localHighFlag(lhF),
    .localLowFlag(llF), .remoteHighFlag(rhF), .remoteLowFlag(rlF));
  crl_conv_model i_crl_conv_model (.clock(clock), .rstn(rstn), .convStart(convStart),
    .locIn(locIn), .remIn(remIn), .resultValid(resultValid), .localResult(localResult),
    .remoteResult(remoteResult));
  // ==========================================================
  // helpers
  task check(string name, logic [7:0] seen, logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tallyAndFinish;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task wr(logic [7:0] p, logic [7:0] v);
    @(posedge clock);
    #1 wrStrobe = 1;
    wrPtr = p;
    wrData = v;
    @(posedge clock);
    #1 wrStrobe = 0;
  endtask
  task rd(logic [7:0] p, logic [7:0] e);
    @(posedge clock);
    #1 rdPtr = p;
    look = 1;
    expQ.push_back(e);
    @(posedge clock);
    #1 look = 0;
  endtask
  // edges from one start pulse to the next
  task period(output int c);
    @(posedge clock iff convStart);
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (!convStart);
  endtask
  task waitIdle;
    for (int i = 0; i < 300 && shutdownIdle !== 1'b1; i++) @(posedge clock);
    check("shutdownIdle", {7'h0, shutdownIdle}, 8'h01);
  endtask
  // ==========================================================
  // clock, watchdog, monitor taking the oldest note per result
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 6000);
    nErrors++;
    tallyAndFinish;
  end
  always @(posedge clock) begin
    lookD <= look;
    flagD <= resultValid;
    if (lookD) check("rdData", rdData, expQ.pop_front());
    if (flagD && flagQ.size() > 0) begin
      check("flags", {4'h0, lhF, llF, rhF, rlF}, flagQ.pop_front());
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {rstn, wrStrobe, look, powerDown} = '0;
    {wrPtr, wrData, rdPtr, locIn, remIn} = '0;
    void'($urandom(32'h976B));
    repeat (2) @(posedge clock);
    #1 rstn = 1;
    foreach (rsP[i]) rd(rsP[i], rsV[i]);
    foreach (wrP[i]) begin
      d = 8'($urandom);
      wr(wrP[i], d);
      rd(rsP[i], i == 0 ? d & 8'h0F : d);
    end
    // period per code, above 09h runs as 09h
    foreach (codes[i]) begin
      wr(WR_RATE, codes[i]);
      period(cyc);
      period(cyc);
      check("period", 8'(cyc),
        8'(FAST << (9 - (codes[i] > 8'h09 ? 9 : int'(codes[i])))));
    end
    // trigger while running keeps the schedule
    @(posedge clock iff convStart);
    repeat (15) @(posedge clock);
    wr(WR_ONE_SHOT, 8'($urandom));
    cyc = 17;
    do begin
      @(posedge clock);
      cyc++;
    end while (!convStart);
    check("period", 8'(cyc), 8'(FAST));
    // one-shots in shutdown with limit edges
    wr(WR_LOC_HIGH, 8'h40);
    wr(WR_LOC_LOW, 8'h10);
    wr(WR_REM_HIGH, 8'h50);
    wr(WR_REM_LOW, 8'h20);
    @(posedge clock);
    #1 powerDown = 1;
    waitIdle();
    for (int i = 0; i < 6; i++) begin
      lv = i < 4 ? lt[i] : 8'($urandom);
      rv = i < 4 ? rt[i] : 8'($urandom);
      flagQ.push_back({4'h0, lv > 8'h40, lv < 8'h10, rv > 8'h50, rv < 8'h20});
      #1 locIn = {lv, 4'($urandom)};
      remIn = {rv, 4'($urandom)};
      wr(WR_ONE_SHOT, 8'($urandom));
      waitIdle();
    end
    #1 powerDown = 0;
    period(cyc);
    check("period", 8'(cyc), 8'(FAST));
    repeat (5) @(posedge clock);
    tallyAndFinish;
  end
endmodule
